// file: hw/user_card_pkg.sv
package user_card_pkg;

  // register indexes; byte address is four times the index
  localparam int IDX_W = 3;
  localparam int ADDR_W = 5;
  localparam logic [IDX_W-1:0] IDX_STATUS = 3'h0;
  localparam logic [IDX_W-1:0] IDX_SETTINGS = 3'h1;
  localparam logic [IDX_W-1:0] IDX_CLOCK = 3'h2;
  localparam logic [IDX_W-1:0] IDX_EARLY_HI = 3'h3;
  localparam logic [IDX_W-1:0] IDX_MASK = 3'h4;

  // status bit positions
  localparam int ST_ACTIVE = 7;
  localparam int ST_EARLY = 6;
  localparam int ST_MISSING = 5;
  localparam int ST_OVERCURRENT = 4;
  localparam int ST_INTERNAL = 3;
  localparam int ST_INSREM = 2;
  localparam int ST_PRESENT = 1;
  localparam int ST_RAMP = 0;
  // flags that stick until the status register is read
  localparam logic [7:0] COR_MASK = 8'h75;

  // settings fields
  localparam int SET_SUPPLY_HI = 7;
  localparam int SET_SUPPLY_LO = 6;
  localparam int SET_IO_CONNECT = 5;
  localparam int SET_WARM = 3;
  localparam int SET_POLARITY = 2;
  localparam int SET_ACTIVATE = 0;
  localparam logic [7:0] SETTINGS_RST = 8'h60;

  // clock settings fields
  localparam int CK_INTERNAL = 7;
  localparam int CK_FORCE_LOW = 6;
  localparam int CK_FORCE_HIGH = 5;
  localparam int CK_DIV_HI = 4;
  localparam int CK_DIV_LO = 2;
  localparam logic [7:0] CLOCK_RST = 8'h0C;
  localparam logic [7:0] CLOCK_WMASK = 8'hFC;

  localparam logic [7:0] EARLY_HI_RST = 8'hAA;
  localparam logic [7:0] MASK_RST = 8'h00;

  // internal card clock: about 1.2 MHz from the 10 MHz core clock
  localparam longint CORE_CLK_HZ = 10000000;
  localparam longint INT_CLK_HZ = 1200000;
  localparam int INT_DIV = int'(CORE_CLK_HZ / INT_CLK_HZ);
  localparam int CNT_W = 4;

  typedef enum logic [1:0] {
    SRC_LOW,
    SRC_HIGH,
    SRC_INPUT,
    SRC_DIV
  } clk_src_e;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } avmm_req_s;

  typedef struct packed {
    logic answer_too_soon;
    logic answer_missing;
    logic overcurrent;
    logic ramp_fault;
    logic auto_deactivate;
  } slot_events_s;

endpackage : user_card_pkg

// file: hw/user_card_ctrl_status_regs.sv
`timescale 1ns/1ps
// Summary of operation
// - status bit 7 shows interface active, live supply_stable_i level, not reset
// - bit 6 sets on early answer, clear-on-read
// - bit 5 sets on missing answer, clear-on-read
// - bit 4 sets on overcurrent, clear-on-read
// - bit 3 shows internal clock in use
// - bit 2 sets on insertion/extraction, clear-on-read
// - bit 1 shows card presence
// - bit 0 sets on supply ramp fault, clear-on-read
// - settings 7:6 select supply, default 01
// - settings bit 5 connects IO lines, default 1
// - warm reset bit starts, self-clears, async only
// - settings bit 2 sets presence pin polarity
// - bit 0 activates/deactivates, async only; auto-deactivation clears it
// - clock bit 7 selects internal clock, sync mode off
// - clock bit 6 forces card clock low unless internal clock in use
// - clock bit 5 forces high, sync needs enable 0
// - async divider 1,2,4,5,8, default 011
// - sync divider gives undivided clock when enabled
module user_card_ctrl_status_regs
  import user_card_pkg::*;
#(
  parameter int INT_CLK_DIV = INT_DIV
) (
  // clock, reset, freeze
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // avalon-mm slave
  input wire avmm_req_s avs_req_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  // slot events and levels from the sequencer (same clock)
  input wire slot_events_s events_i,
  input wire logic supply_stable_i,
  input wire logic sync_mode_i,
  input wire logic manual_mode_i,
  input wire logic sync_clk_enable_i,
  // card presence pin (asynchronous)
  input wire logic card_sense_input_i,
  // slot controls
  output logic [1:0] supply_select_o,
  output logic io_connect_o,
  output logic warm_reset_start_o,
  output logic async_activate_o,
  output logic [7:0] early_count_high_o,
  output logic slot_irq_summary_o,
  output logic card_clock_output_o
);

  // refuse dividers the counter cannot hold
  if (INT_CLK_DIV < 2 || INT_CLK_DIV > (1 << CNT_W) - 1) begin : g_bad_div
    $error("INT_CLK_DIV out of range");
  end

  // bus decode
  wire logic [IDX_W-1:0] idx = avs_req_i.address[ADDR_W-1:2];
  wire logic req = avs_req_i.read | avs_req_i.write;
  wire logic lane0 = avs_req_i.byteenable[0];
  wire logic [7:0] wdata = avs_req_i.writedata[7:0];
  wire logic hit_status = (idx == IDX_STATUS);
  wire logic hit_settings = (idx == IDX_SETTINGS);
  wire logic hit_clock = (idx == IDX_CLOCK);
  wire logic hit_early = (idx == IDX_EARLY_HI);
  wire logic hit_mask = (idx == IDX_MASK);

  logic ack_q;
  logic [7:0] rdata_q;
  logic [7:0] flags_q;
  logic [7:0] settings_q;
  logic [7:0] clock_q;
  logic [7:0] early_hi_q;
  logic [7:0] mask_q;
  logic warm_pulse_q;
  logic irq_q;
  logic summary_q;
  logic sense_meta_q;
  logic sense_q;
  logic sense_prev_q;
  logic sense_valid_q;
  logic [1:0] sense_warm_q;
  logic [CNT_W-1:0] div_cnt_q;
  logic div_clk_q;
  logic use_input_q;

  // the second edge of a request accepts it; one wait state always
  wire logic accept = req & ack_q;
  wire logic wr_acc = accept & avs_req_i.write & lane0;
  wire logic rd_status = accept & avs_req_i.read & hit_status;
  assign avs_waitrequest_o = req & ~ack_q;

  // mode qualifiers
  wire logic async_mode = ~sync_mode_i & ~manual_mode_i;
  wire logic async_clk = ~sync_mode_i;

  // presence follows the chosen polarity of the synchronised pin
  wire logic present = settings_q[SET_POLARITY] ? sense_q : ~sense_q;
  wire logic sense_edge = sense_valid_q & (sense_q ^ sense_prev_q);

  // internal clock in force only while sync mode is off (async or manual mode)
  wire logic internal_on = async_clk & clock_q[CK_INTERNAL];

  // hardware events for the sticky flags
  wire logic [7:0] ev;
  assign ev[ST_ACTIVE] = 1'b0;
  assign ev[ST_EARLY] = events_i.answer_too_soon;
  assign ev[ST_MISSING] = events_i.answer_missing;
  assign ev[ST_OVERCURRENT] = events_i.overcurrent;
  assign ev[ST_INTERNAL] = 1'b0;
  assign ev[ST_INSREM] = sense_edge;
  assign ev[ST_PRESENT] = 1'b0;
  assign ev[ST_RAMP] = events_i.ramp_fault;

  // live status word: sticky flags plus level bits
  wire logic [7:0] status_val;
  assign status_val[ST_ACTIVE] = supply_stable_i;
  assign status_val[ST_EARLY] = flags_q[ST_EARLY];
  assign status_val[ST_MISSING] = flags_q[ST_MISSING];
  assign status_val[ST_OVERCURRENT] = flags_q[ST_OVERCURRENT];
  assign status_val[ST_INTERNAL] = internal_on;
  assign status_val[ST_INSREM] = flags_q[ST_INSREM];
  assign status_val[ST_PRESENT] = present;
  assign status_val[ST_RAMP] = flags_q[ST_RAMP];

  // read mux; unmapped indexes read zero
  wire logic [7:0] rd_mux = hit_status ? status_val :
                            hit_settings ? settings_q :
                            hit_clock ? clock_q :
                            hit_early ? early_hi_q :
                            hit_mask ? mask_q : 8'h00;

  // clear exactly what the read returned; later events survive
  wire logic [7:0] clr = rd_status ? (rdata_q & COR_MASK) : 8'h00;
  wire logic [7:0] flags_d = ((flags_q & ~clr) | ev) & COR_MASK;

  // settings write: warm and activate honoured only in async mode
  wire logic [7:0] set_wr;
  assign set_wr[SET_SUPPLY_HI] = wdata[SET_SUPPLY_HI];
  assign set_wr[SET_SUPPLY_LO] = wdata[SET_SUPPLY_LO];
  assign set_wr[SET_IO_CONNECT] = wdata[SET_IO_CONNECT];
  assign set_wr[4] = 1'b0;
  assign set_wr[SET_WARM] = wdata[SET_WARM] & async_mode;
  assign set_wr[SET_POLARITY] = wdata[SET_POLARITY];
  assign set_wr[1] = 1'b0;
  assign set_wr[SET_ACTIVATE] = async_mode ? wdata[SET_ACTIVATE] :
                                settings_q[SET_ACTIVATE];

  // warm bit lives one cycle, then self-clears as the sequence starts
  wire logic [7:0] set_hw;
  assign set_hw = {settings_q[7:4],
                   1'b0,
                   settings_q[2:1],
                   settings_q[SET_ACTIVATE] & ~events_i.auto_deactivate};
  // a software write in the same cycle as auto-deactivation wins
  wire logic [7:0] settings_d = (wr_acc & hit_settings) ? set_wr : set_hw;

  // bus handshake and read capture
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
    end else if (ce_i) begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q & avs_req_i.read) begin
        rdata_q <= rd_mux;
      end
    end
  end
  assign avs_readdata_o = {24'h000000, rdata_q};

  // sticky flags; a set in the clearing cycle wins
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      flags_q <= 8'h00;
    end else if (ce_i) begin
      flags_q <= flags_d;
    end
  end

  // software-written registers
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      settings_q <= SETTINGS_RST;
      clock_q <= CLOCK_RST;
      early_hi_q <= EARLY_HI_RST;
      mask_q <= MASK_RST;
    end else if (ce_i) begin
      settings_q <= settings_d;
      if (wr_acc & hit_clock) begin
        clock_q <= wdata & CLOCK_WMASK;
      end
      if (wr_acc & hit_early) begin
        early_hi_q <= wdata;
      end
      if (wr_acc & hit_mask) begin
        mask_q <= wdata & COR_MASK;
      end
    end
  end

  // warm start pulse and interrupt outputs
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      warm_pulse_q <= 1'b0;
      irq_q <= 1'b0;
      summary_q <= 1'b0;
    end else if (ce_i) begin
      warm_pulse_q <= settings_q[SET_WARM];
      irq_q <= |(flags_d & mask_q);
      summary_q <= |flags_d;
    end
  end

  // two-flop synchroniser for the presence pin
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sense_meta_q <= 1'b0;
      sense_q <= 1'b0;
      sense_prev_q <= 1'b0;
      sense_valid_q <= 1'b0;
      sense_warm_q <= 2'h0;
    end else if (ce_i) begin
      sense_meta_q <= card_sense_input_i;
      sense_q <= sense_meta_q;
      sense_prev_q <= sense_q;
      // no edge reported until both compared stages hold real samples,
      // so a pin idling high does not fake an insertion after reset
      sense_warm_q <= {sense_warm_q[0], 1'b1};
      sense_valid_q <= sense_warm_q[1];
    end
  end

  // card clock source selection by priority
  wire logic [2:0] div_code = clock_q[CK_DIV_HI:CK_DIV_LO];
  wire logic [CNT_W-1:0] div_period =
    internal_on ? CNT_W'(INT_CLK_DIV) :
    div_code[2] ? CNT_W'(8) :
    (div_code[1:0] == 2'b11) ? CNT_W'(5) :
    (div_code[1:0] == 2'b10) ? CNT_W'(4) :
    (div_code[1:0] == 2'b01) ? CNT_W'(2) : CNT_W'(1);
  wire logic force_low = clock_q[CK_FORCE_LOW];
  wire logic force_high = clock_q[CK_FORCE_HIGH] &
                          (async_clk | ~sync_clk_enable_i);
  clk_src_e src;
  assign src = (internal_on) ? SRC_DIV :
               force_low ? SRC_LOW :
               force_high ? SRC_HIGH :
               (~async_clk & ~sync_clk_enable_i) ? SRC_LOW :
               (~async_clk) ? SRC_INPUT :
               (div_period == CNT_W'(1)) ? SRC_INPUT : SRC_DIV;

  // half-period threshold; odd periods spend the extra cycle low
  wire logic [CNT_W-1:0] half = div_period >> 1;
  wire logic cnt_wrap = (div_cnt_q >= div_period - CNT_W'(1));

  // divider counter and registered card clock level
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      div_cnt_q <= '0;
      div_clk_q <= 1'b0;
      use_input_q <= 1'b0;
    end else if (ce_i) begin
      div_cnt_q <= cnt_wrap ? '0 : div_cnt_q + CNT_W'(1);
      use_input_q <= (src == SRC_INPUT);
      case (src)
        SRC_LOW: begin
          div_clk_q <= 1'b0;
        end
        SRC_HIGH: begin
          div_clk_q <= 1'b1;
        end
        SRC_DIV: begin
          div_clk_q <= (cnt_wrap ? '0 : div_cnt_q + CNT_W'(1)) < half;
        end
        default: begin
          div_clk_q <= 1'b0;
        end
      endcase
    end
  end

  // undivided path passes the core clock itself; switch is registered
  // so the mux select never changes mid high phase of the core clock
  assign card_clock_output_o = use_input_q ? core_clk_i : div_clk_q;

  // control outputs
  assign supply_select_o = settings_q[SET_SUPPLY_HI:SET_SUPPLY_LO];
  assign io_connect_o = settings_q[SET_IO_CONNECT];
  assign warm_reset_start_o = warm_pulse_q;
  assign async_activate_o = settings_q[SET_ACTIVATE];
  assign early_count_high_o = early_hi_q;
  assign slot_irq_summary_o = summary_q;
  assign irq_o = irq_q;

endmodule : user_card_ctrl_status_regs

// file: verification/card_slot_model.sv
`timescale 1ns/1ps
module card_slot_model (
  // card state and detect wiring of the slot
  input wire logic present_i,
  input wire logic polarity_i,
  // presence pin toward the block
  output logic card_sense_input_o
);
  // polarity 1: a card pulls the pin high; 0: it pulls it low
  assign card_sense_input_o = ~(present_i ^ polarity_i);
endmodule : card_slot_model

// file: verification/user_card_ctrl_status_regs_monitor.sv
`timescale 1ns/1ps
module card_regs_monitor
  import user_card_pkg::*;
(
  // clock and inputs
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire avmm_req_s avs_req_i,
  input wire slot_events_s events_i,
  input wire logic sync_mode_i,
  input wire logic manual_mode_i,
  input wire logic card_sense_input_i,
  // outputs under watch
  input wire logic avs_waitrequest_o,
  input wire logic [1:0] supply_select_o,
  input wire logic io_connect_o,
  input wire logic warm_reset_start_o,
  input wire logic async_activate_o,
  input wire logic [7:0] early_count_high_o,
  input wire logic slot_irq_summary_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // an accepted settings write lands at the edge it is seen on
  wire logic req_on = avs_req_i.read | avs_req_i.write;
  wire logic set_wr = ce_i & avs_req_i.write & ~avs_waitrequest_o &
    avs_req_i.byteenable[0] & (avs_req_i.address == 5'h04);
  wire logic async_ok = ~sync_mode_i & ~manual_mode_i;
  property p_reset_vals;
    $fell(sys_rst_i) |-> supply_select_o == 2'b01 && io_connect_o &&
      !async_activate_o && early_count_high_o == 8'hAA;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("control defaults wrong after reset");
  property p_one_wait;
    ce_i && req_on && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("bus stalled more than one cycle");
  property p_event_sum;
    ce_i && (|events_i[4:1]) |=> slot_irq_summary_o;
  endproperty
  a_event_sum: assert property (p_event_sum)
    else $error("slot event did not raise the summary");
  property p_warm_go;
    set_wr && async_ok && avs_req_i.writedata[3] |-> ##[1:2]
      warm_reset_start_o;
  endproperty
  a_warm_go: assert property (p_warm_go)
    else $error("warm reset did not start");
  property p_refused;
    set_wr && !async_ok |=> ($stable(async_activate_o) &&
      !warm_reset_start_o) [*3];
  endproperty
  a_refused: assert property (p_refused)
    else $error("start bits acted outside async mode");
  property p_act;
    set_wr && async_ok |=> async_activate_o == $past(avs_req_i.writedata[0]);
  endproperty
  a_act: assert property (p_act)
    else $error("activate output did not follow the write");
  property p_auto;
    ce_i && events_i.auto_deactivate && !set_wr |=> !async_activate_o;
  endproperty
  a_auto: assert property (p_auto)
    else $error("auto deactivation left activate set");
  property p_sense;
    ce_i && $changed(card_sense_input_i) |-> ##[3:6] slot_irq_summary_o;
  endproperty
  a_sense: assert property (p_sense)
    else $error("pin edge did not raise the summary");
endmodule : card_regs_monitor

bind user_card_ctrl_status_regs card_regs_monitor mon_u (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
  .avs_req_i(avs_req_i), .events_i(events_i), .sync_mode_i(sync_mode_i),
  .manual_mode_i(manual_mode_i), .card_sense_input_i(card_sense_input_i),
  .avs_waitrequest_o(avs_waitrequest_o), .supply_select_o(supply_select_o),
  .io_connect_o(io_connect_o), .warm_reset_start_o(warm_reset_start_o),
  .async_activate_o(async_activate_o),
  .early_count_high_o(early_count_high_o),
  .slot_irq_summary_o(slot_irq_summary_o));

// file: verification/user_card_ctrl_status_regs_tb_top.sv
`timescale 1ns/1ps
module user_card_ctrl_status_regs_tb_top;
  import user_card_pkg::*;
  localparam int IDIV = 8;
  typedef struct packed {
    logic wr;
    logic [4:0] a;
    logic [3:0] be;
    logic [7:0] d;
  } row_s;
  // register table: a read row carries the value it must return
  row_s rows [17] = '{
    '{1'b0, 5'h00, 4'h1, 8'h02}, '{1'b0, 5'h04, 4'h1, 8'h60},
    '{1'b0, 5'h08, 4'h1, 8'h0C}, '{1'b0, 5'h0C, 4'h1, 8'hAA},
    '{1'b0, 5'h10, 4'h1, 8'h00}, '{1'b0, 5'h14, 4'h1, 8'h00},
    '{1'b1, 5'h04, 4'h1, 8'hC0}, '{1'b0, 5'h04, 4'h1, 8'hC0},
    '{1'b1, 5'h08, 4'h1, 8'hFF}, '{1'b0, 5'h08, 4'h1, 8'hFC},
    '{1'b1, 5'h10, 4'h1, 8'hFF}, '{1'b0, 5'h10, 4'h1, 8'h75},
    '{1'b1, 5'h14, 4'h1, 8'h5A}, '{1'b0, 5'h14, 4'h1, 8'h00},
    '{1'b1, 5'h0C, 4'h1, 8'h3C}, '{1'b1, 5'h0C, 4'h0, 8'h77},
    '{1'b0, 5'h0C, 4'h1, 8'h3C}};
  logic [7:0] ebit [4] = '{8'h40, 8'h20, 8'h10, 8'h01};
  int divs [8] = '{1, 2, 4, 5, 8, 8, 8, 8};
  // stimulus, always changed just after a rising edge
  logic clk = 1'b0;
  logic rst = 1'b1;
  avmm_req_s req = '0;
  slot_events_s ev = '0;
  logic stable = 1'b0, sync_m = 1'b0, man_m = 1'b0, sync_en = 1'b0;
  logic present = 1'b1;
  logic sense, wait_o, irq, warm, act, summ, cclk, io_con;
  logic [31:0] rdata;
  logic [1:0] vsel;
  logic [7:0] early_hi, rd;
  int fail_count = 0, checks = 0, cyc = 0, edges = 0, warms = 0;
  always #50 clk = ~clk;
  user_card_ctrl_status_regs #(.INT_CLK_DIV(IDIV)) dut_u (
    .core_clk_i(clk), .sys_rst_i(rst), .ce_i(1'b1), .avs_req_i(req),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o), .irq_o(irq),
    .events_i(ev), .supply_stable_i(stable), .sync_mode_i(sync_m),
    .manual_mode_i(man_m), .sync_clk_enable_i(sync_en),
    .card_sense_input_i(sense), .supply_select_o(vsel),
    .io_connect_o(io_con), .warm_reset_start_o(warm),
    .async_activate_o(act), .early_count_high_o(early_hi),
    .slot_irq_summary_o(summ), .card_clock_output_o(cclk));
  card_slot_model card_u (.present_i(present), .polarity_i(1'b0),
    .card_sense_input_o(sense));
  // card clock edges and warm pulses are counted, not sampled
  always @(cclk) edges++;
  always @(posedge clk) if (warm) warms++;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // edge counts may be off by one from window phase
  task automatic chk_rng(input int got, input int exp);
    checks++;
    if (got > exp + 1 || got < exp - 1) begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_rng
  task automatic bus(input logic w, input logic [4:0] a,
    input logic [3:0] be, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{~w, w, a, be, {24'h0, d}};
    // waitrequest is sampled at the rising edge; the request holds until
    // the edge that sees it low, and read data is taken at that same edge
    do begin
      @(posedge clk);
      n++;
    end while (wait_o !== 1'b0 && n < 50);
    if (n >= 50) begin
      fail_count++;
      stop_test();
    end
    rd = rdata[7:0];
    req <= '0;
  endtask : bus
  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 4'h1, 8'h00);
    chk(rd, e);
  endtask : rchk
  task automatic pulse(input slot_events_s e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= '0;
    repeat (2) @(posedge clk);
  endtask : pulse
  task automatic clk_meas(input logic [7:0] ck, input logic s,
    input logic en, input int ex, input logic lv);
    bus(1'b1, 5'h08, 4'h1, ck);
    sync_m <= s;
    sync_en <= en;
    repeat (20) @(posedge clk);
    edges = 0;
    repeat (40) @(posedge clk);
    chk_rng(edges, ex);
    if (ex == 0) chk({7'h0, cclk}, {7'h0, lv});
  endtask : clk_meas
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) bus(1'b1, rows[i].a, rows[i].be, rows[i].d);
      else rchk(rows[i].a, rows[i].d);
    end
    chk({5'h0, vsel, io_con}, 8'h06);
    chk(early_hi, 8'h3C);
    bus(1'b1, 5'h04, 4'h1, 8'h60);
    $display("test register table done");
    for (int c = 0; c < 8; c++)
      clk_meas({3'h0, c[2:0], 2'h0}, 0, 0, 80 / divs[c], 0);
    clk_meas(8'h60, 0, 0, 0, 0);
    clk_meas(8'h20, 0, 0, 0, 1);
    clk_meas(8'hA0, 0, 0, 80 / IDIV, 0);
    rchk(5'h00, 8'h0A);
    clk_meas(8'h90, 1, 1, 80, 0);
    rchk(5'h00, 8'h02);
    clk_meas(8'h40, 1, 1, 0, 0);
    clk_meas(8'h20, 1, 0, 0, 1);
    clk_meas(8'h00, 1, 0, 0, 0);
    clk_meas(8'h0C, 0, 0, 16, 0);
    $display("test card clock done");
    for (int i = 0; i < 4; i++) begin
      pulse(slot_events_s'(5'h10 >> i));
      chk({6'h0, irq, summ}, 8'h03);
      rchk(5'h00, 8'h02 | ebit[i]);
      rchk(5'h00, 8'h02);
      chk({6'h0, irq, summ}, 8'h00);
    end
    bus(1'b1, 5'h10, 4'h1, 8'h00);
    pulse(slot_events_s'(5'h02));
    chk({6'h0, irq, summ}, 8'h01);
    rchk(5'h00, 8'h03);
    $display("test status flags done");
    stable <= 1'b1;
    present <= 1'b0;
    repeat (8) @(posedge clk);
    rchk(5'h00, 8'h84);
    rchk(5'h00, 8'h80);
    bus(1'b1, 5'h04, 4'h1, 8'h64);
    rchk(5'h00, 8'h82);
    $display("test presence done");
    for (int m = 0; m < 3; m++) begin
      sync_m <= (m == 1);
      man_m <= (m == 2);
      warms = 0;
      bus(1'b1, 5'h04, 4'h1, 8'h69);
      repeat (4) @(posedge clk);
      chk({6'h0, warms == 1, act}, m == 0 ? 8'h03 : 8'h00);
      pulse(slot_events_s'(5'h01));
      rchk(5'h04, 8'h60);
    end
    $display("test start bits done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk(5'h08, 8'h0C);
    $display("test second reset done");
    stop_test();
  end
endmodule : user_card_ctrl_status_regs_tb_top
